// ===== rtl/ext_irq_and_timer_flag_ctrl.sv
`timescale 1ns/1ps
`include "ext_irq_map.svh"
module ext_irq_and_timer_flag_ctrl (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire ext_irq_pkg::timer_evt_s   timer_evt,
    input  wire ext_irq_pkg::timer_evt_s   timer_vec_ack,
    input  wire logic [2:0]                ext_vec_ack,
    input  wire logic                      ext_irq_pin_a,
    input  wire logic                      ext_irq_pin_b,
    input  wire logic                      ext_irq_pin_c,
    input  wire logic                      sleep_instr,
    output logic [4:0]                     timer_irq_req,
    output logic [2:0]                     ext_irq_req,
    output logic                           sleep_enter,
    output ext_irq_pkg::sleep_mode_e       sleep_mode,
    output ext_irq_pkg::ext_mem_cfg_s      ext_mem_cfg
);

    logic [7:0]  mcu_control;
    logic [7:0]  extended_mcu_control;
    logic [4:0]  timer_irq_flags;
    logic [4:0]  timer_irq_mask;
    logic [2:0]  ext_flags;
    logic [2:0]  ext_mask;
    logic        global_ie;
    logic [4:0]  next_timer_flags;
    logic [2:0]  next_ext_flags;
    logic [1:0]  pin_meta;
    logic [1:0]  pin_now;
    logic [1:0]  pin_prev;
    logic [1:0]  edge_evt;
    logic [1:0]  level_req;
    logic        pin_c_clk;
    logic        pin_c_toggle;
    logic        pin_c_meta;
    logic        pin_c_now;
    logic        pin_c_prev;
    logic        pin_c_evt;
    logic        setup;
    logic        wr;
    logic [9:0]  idx;
    logic [7:0]  rd_byte;
    logic        mapped;
    ext_irq_pkg::sense_e sense [1:0];

    function automatic logic is_reg(input logic [11:0] a,
                                    input logic [9:0]  i);
        return (a[1:0] == 2'h0) && (a[11:2] == i);
    endfunction

    // group register order b,a,c -> internal order c,b,a
    function automatic logic [2:0] to_abc(input logic [7:0] v);
        return {v[`G_BIT_C], v[`G_BIT_B], v[`G_BIT_A]};
    endfunction

    function automatic logic [7:0] from_abc(input logic [2:0] v);
        logic [7:0] r;
        r = 8'h00;
        r[`G_BIT_A] = v[0];
        r[`G_BIT_B] = v[1];
        r[`G_BIT_C] = v[2];
        return r;
    endfunction

    function automatic logic sense_event(input ext_irq_pkg::sense_e m,
                                         input logic now,
                                         input logic prev);
        logic e;
        e = 1'b0;
        case (m)
            ext_irq_pkg::SENSE_ANY:  e = now ^ prev;
            ext_irq_pkg::SENSE_FALL: e = prev & ~now;
            ext_irq_pkg::SENSE_RISE: e = ~prev & now;
            default:                 e = 1'b0;
        endcase
        return e;
    endfunction

    // apb decode; zero wait state, answer in the access phase
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready & pwrite;
    assign idx   = paddr[11:2];

    always_comb begin
        rd_byte = 8'h00;
        mapped  = 1'b1;
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else begin
            case (idx)
                `IDX_MCU_CONTROL: rd_byte = mcu_control;
                `IDX_EXT_CONTROL: rd_byte = extended_mcu_control;
                `IDX_TIMER_FLAGS: rd_byte = {3'h0, timer_irq_flags};
                `IDX_TIMER_MASK:  rd_byte = {3'h0, timer_irq_mask};
                `IDX_GEN_FLAGS:   rd_byte = from_abc(ext_flags);
                `IDX_GEN_MASK:    rd_byte = from_abc(ext_mask);
                `IDX_CPU_STATUS:  rd_byte = {global_ie, 7'h00};
                default:          mapped  = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcu_control          <= `REG_RESET;
            extended_mcu_control <= `REG_RESET;
            timer_irq_mask       <= 5'h00;
            ext_mask             <= 3'h0;
            global_ie            <= 1'b0;
        end else if (wr) begin
            if (is_reg(paddr, `IDX_MCU_CONTROL)) begin
                mcu_control <= pwdata[7:0];
            end
            if (is_reg(paddr, `IDX_EXT_CONTROL)) begin
                extended_mcu_control <= pwdata[7:0];
            end
            if (is_reg(paddr, `IDX_TIMER_MASK)) begin
                timer_irq_mask <= pwdata[4:0];
            end
            if (is_reg(paddr, `IDX_GEN_MASK)) begin
                ext_mask <= to_abc(pwdata[7:0]);
            end
            if (is_reg(paddr, `IDX_CPU_STATUS)) begin
                global_ie <= pwdata[`STATUS_IBIT];
            end
        end
    end

    // timer flags: vector entry or written one clears, event sets
    always_comb begin
        next_timer_flags = timer_irq_flags & ~timer_vec_ack;
        if (wr && is_reg(paddr, `IDX_TIMER_FLAGS)) begin
            next_timer_flags = next_timer_flags & ~pwdata[4:0];
        end
        next_timer_flags = next_timer_flags | timer_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_flags <= 5'h00;
        end else begin
            timer_irq_flags <= next_timer_flags;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_req <= 5'h00;
        end else begin
            timer_irq_req <= next_timer_flags & timer_irq_mask
                             & {5{global_ie}};
        end
    end

    // pins a and b: two-stage synchroniser, then a history stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 2'h3;
            pin_now  <= 2'h3;
            pin_prev <= 2'h3;
        end else begin
            pin_meta <= {ext_irq_pin_b, ext_irq_pin_a};
            pin_now  <= pin_meta;
            pin_prev <= pin_now;
        end
    end

    assign sense[0] = ext_irq_pkg::sense_e'(
        mcu_control[`MCU_SENSE_A_LSB +: 2]);
    assign sense[1] = ext_irq_pkg::sense_e'(
        mcu_control[`MCU_SENSE_B_LSB +: 2]);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            edge_evt[i]  = sense_event(sense[i], pin_now[i],
                                       pin_prev[i]);
            level_req[i] = (sense[i] == ext_irq_pkg::SENSE_LOW)
                           & ~pin_now[i];
        end
    end

    // pin c: edge caught by the pin itself; a change of the edge
    // select may itself look like an edge
    assign pin_c_clk = ext_irq_pin_c
                       ^ ~extended_mcu_control[`EXT_PIN_C_EDGE];

    always_ff @(posedge pin_c_clk or negedge presetn) begin
        if (!presetn) begin
            pin_c_toggle <= 1'b0;
        end else begin
            pin_c_toggle <= ~pin_c_toggle;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_c_meta <= 1'b0;
            pin_c_now  <= 1'b0;
            pin_c_prev <= 1'b0;
        end else begin
            pin_c_meta <= pin_c_toggle;
            pin_c_now  <= pin_c_meta;
            pin_c_prev <= pin_c_now;
        end
    end

    assign pin_c_evt = pin_c_now ^ pin_c_prev;

    always_comb begin
        next_ext_flags = ext_flags & ~ext_vec_ack;
        if (wr && is_reg(paddr, `IDX_GEN_FLAGS)) begin
            next_ext_flags = next_ext_flags & ~to_abc(pwdata[7:0]);
        end
        next_ext_flags = next_ext_flags | {pin_c_evt, edge_evt};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_flags   <= 3'h0;
            ext_irq_req <= 3'h0;
        end else begin
            ext_flags   <= next_ext_flags;
            ext_irq_req <= (next_ext_flags | {1'b0, level_req})
                           & ext_mask & {3{global_ie}};
        end
    end

    // sleep request only with the enable bit set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_enter <= 1'b0;
        end else begin
            sleep_enter <= sleep_instr
                           & mcu_control[`MCU_SLEEP_EN];
        end
    end

    assign sleep_mode = ext_irq_pkg::sleep_mode_e'(
        {mcu_control[`MCU_SLEEP_HI],
         extended_mcu_control[`EXT_SLEEP_LO]});

    assign ext_mem_cfg.enable       = mcu_control[`MCU_MEM_EN];
    assign ext_mem_cfg.wait_upper_a =
        mcu_control[`MCU_WAIT_UPPER_A];
    assign ext_mem_cfg.limit        =
        extended_mcu_control[`EXT_LIMIT_LSB +: 3];
    assign ext_mem_cfg.wait_sel     =
        extended_mcu_control[`EXT_WAIT_LSB +: 3];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_t2_ovf_set;
        timer_evt.timer2_overflow |=> timer_irq_flags[`TF_T2_OVF];
    endproperty
    a_t2_ovf_set: assert property (p_t2_ovf_set)
        else $error("timer2 overflow flag not set");

    property p_capture_set;
        timer_evt.capture && timer_vec_ack.capture
            |=> timer_irq_flags[`TF_CAPTURE];
    endproperty
    a_capture_set: assert property (p_capture_set)
        else $error("capture flag lost against ack");

    property p_t2_cmp_set;
        timer_evt.timer2_compare |=>
            timer_irq_flags[`TF_T2_CMP] && $past(timer_evt.timer2_compare);
    endproperty
    a_t2_cmp_set: assert property (p_t2_cmp_set)
        else $error("timer2 compare flag not set");

    property p_t0_ovf_req;
        timer_evt.timer0_overflow && global_ie
            && timer_irq_mask[`TF_T0_OVF]
            && !(wr && is_reg(paddr, `IDX_TIMER_MASK))
            && !(wr && is_reg(paddr, `IDX_CPU_STATUS))
            |=> timer_irq_req[`TF_T0_OVF];
    endproperty
    a_t0_ovf_req: assert property (p_t0_ovf_req)
        else $error("timer0 overflow did not request");

    property p_t0_cmp_set;
        $rose(timer_irq_flags[`TF_T0_CMP])
            |-> $past(timer_evt.timer0_compare);
    endproperty
    a_t0_cmp_set: assert property (p_t0_cmp_set)
        else $error("timer0 compare flag rose without event");

    property p_vec_clear;
        timer_vec_ack.timer2_overflow && !timer_evt.timer2_overflow
            |=> !timer_irq_flags[`TF_T2_OVF];
    endproperty
    a_vec_clear: assert property (p_vec_clear)
        else $error("flag survived vector entry");

    property p_w1c_clear;
        wr && is_reg(paddr, `IDX_TIMER_FLAGS) && pwdata[`TF_CAPTURE]
            && !timer_evt.capture && !timer_vec_ack.capture
            |=> !timer_irq_flags[`TF_CAPTURE];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("write one did not clear capture flag");

    property p_timer_gate;
        timer_irq_req != 5'h00 |-> $past(global_ie);
    endproperty
    a_timer_gate: assert property (p_timer_gate)
        else $error("timer request without global enable");

    sequence s_low_held;
        sense[0] == ext_irq_pkg::SENSE_LOW && !pin_now[0]
            && ext_mask[0] && global_ie;
    endsequence
    property p_low_level;
        s_low_held ##1 s_low_held |-> ext_irq_req[0];
    endproperty
    a_low_level: assert property (p_low_level)
        else $error("low level not requesting");

    sequence s_pin_b_fall;
        sense[1] == ext_irq_pkg::SENSE_FALL
            && pin_prev[1] && !pin_now[1];
    endsequence
    property p_fall_b;
        s_pin_b_fall |=> ext_flags[1];
    endproperty
    a_fall_b: assert property (p_fall_b)
        else $error("pin b falling edge not flagged");

    property p_rise_a_sync;
        $rose(ext_flags[0]) && sense[0] == ext_irq_pkg::SENSE_RISE
            |-> $past(pin_now[0]) && !$past(pin_prev[0]);
    endproperty
    a_rise_a_sync: assert property (p_rise_a_sync)
        else $error("pin a flag without sampled rise");

    property p_ext_gate;
        ext_irq_req[1] |-> $past(ext_mask[1]) && $past(global_ie);
    endproperty
    a_ext_gate: assert property (p_ext_gate)
        else $error("external request without mask and global");

    property p_pin_c_flag;
        $changed(pin_c_now) |-> ##1 ext_flags[2];
    endproperty
    a_pin_c_flag: assert property (p_pin_c_flag)
        else $error("pin c edge not flagged");

    property p_sleep_gate;
        sleep_enter |-> $past(sleep_instr)
            && $past(mcu_control[`MCU_SLEEP_EN]);
    endproperty
    a_sleep_gate: assert property (p_sleep_gate)
        else $error("sleep entered without enable");

    property p_mem_enable;
        wr && is_reg(paddr, `IDX_MCU_CONTROL)
            |=> ext_mem_cfg.enable == $past(pwdata[`MCU_MEM_EN]);
    endproperty
    a_mem_enable: assert property (p_mem_enable)
        else $error("memory enable not following write");

    property p_sleep_mode;
        wr && is_reg(paddr, `IDX_EXT_CONTROL)
            |=> sleep_mode[0] == $past(pwdata[`EXT_SLEEP_LO]);
    endproperty
    a_sleep_mode: assert property (p_sleep_mode)
        else $error("sleep mode low bit wrong");

endmodule

// ===== rtl/ext_irq_map.svh
// What this block does
// - timer2 overflow sets flag bit 4
// - capture event sets flag bit 3
// - timer2 compare match sets flag bit 2
// - timer0 overflow sets flag bit 1
// - timer0 compare match sets flag bit 0
// - flags clear on vector or written one
// - timer request needs global, enable, flag
// - pins trigger even when driven as outputs
// - pins a,b level or edge; c edge only
// - low level requests while pin stays low
// - pin b sense field in bits 3..2
// - pin a sense field in bits 1..0
// - pins a,b sampled before edge detection
// - external request needs global and mask bit
// - memory enable bit 7 overrides pin directions
// - sleep only when sleep enable bit set
// - sleep mode from control 4, extended 7
// - control bit 6 extra wait state out
// - extended bits 6..4 hold memory limit
// - extended bits 3..1 wait selects out
// - extended bit 0 picks pin c edge
// - pin c edges caught without core clock
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH
`define IDX_MCU_CONTROL   10'h035
`define IDX_EXT_CONTROL   10'h036
`define IDX_TIMER_FLAGS   10'h038
`define IDX_TIMER_MASK    10'h039
`define IDX_GEN_FLAGS     10'h03a
`define IDX_GEN_MASK      10'h03b
`define IDX_CPU_STATUS    10'h03f
`define REG_RESET         8'h00
`define MCU_MEM_EN        7
`define MCU_WAIT_UPPER_A  6
`define MCU_SLEEP_EN      5
`define MCU_SLEEP_HI      4
`define MCU_SENSE_B_LSB   2
`define MCU_SENSE_A_LSB   0
`define EXT_SLEEP_LO      7
`define EXT_LIMIT_LSB     4
`define EXT_WAIT_LSB      1
`define EXT_PIN_C_EDGE    0
`define TF_T2_OVF         4
`define TF_CAPTURE        3
`define TF_T2_CMP         2
`define TF_T0_OVF         1
`define TF_T0_CMP         0
`define G_BIT_B           7
`define G_BIT_A           6
`define G_BIT_C           5
`define STATUS_IBIT       7
`endif

// ===== rtl/ext_irq_pkg.sv
package ext_irq_pkg;
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'h0,
        SENSE_ANY  = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } sense_e;
    typedef enum logic [1:0] {
        SLEEP_IDLE     = 2'h0,
        SLEEP_RESERVED = 2'h1,
        SLEEP_PWR_DOWN = 2'h2,
        SLEEP_PWR_SAVE = 2'h3
    } sleep_mode_e;
    // bit order matches flag register bits 4..0
    typedef struct packed {
        logic timer2_overflow;
        logic capture;
        logic timer2_compare;
        logic timer0_overflow;
        logic timer0_compare;
    } timer_evt_s;
    typedef struct packed {
        logic       enable;
        logic       wait_upper_a;
        logic [2:0] limit;
        logic [2:0] wait_sel;
    } ext_mem_cfg_s;
endpackage

// ===== dv/ext_irq_partner.sv
`timescale 1ns/1ps
module ext_irq_partner (
    input  wire logic                     pclk,
    input  wire logic [4:0]               timer_irq_req,
    input  wire logic [2:0]               ext_irq_req,
    output ext_irq_pkg::timer_evt_s       timer_vec_ack,
    output logic [2:0]                    ext_vec_ack,
    output logic [2:0]                    pins
);
    initial begin
        timer_vec_ack = '0;
        ext_vec_ack = 3'h0;
        pins = 3'h7;
    end

    // takes one vector, lowest pending source, external ones first
    task automatic take_vector(input int delay);
        logic [2:0] e;
        logic [4:0] t;
        repeat (delay) @(posedge pclk);
        @(posedge pclk);
        e = ext_irq_req & (~ext_irq_req + 3'h1);
        t = (e != 3'h0) ? 5'h0 : (timer_irq_req & (~timer_irq_req + 5'h1));
        ext_vec_ack <= e;
        timer_vec_ack <= t;
        @(posedge pclk);
        ext_vec_ack <= 3'h0;
        timer_vec_ack <= '0;
    endtask

    // a level is held for several clocks so it is always seen
    task automatic drive_pin(input int idx, input logic val, input int hold);
        @(posedge pclk);
        pins <= (pins & ~(3'h1 << idx)) | (3'(val) << idx);
        repeat (hold) @(posedge pclk);
    endtask
endmodule

// ===== dv/ext_irq_and_timer_flag_ctrl_bench.sv
`timescale 1ns/1ps
module ext_irq_and_timer_flag_ctrl_bench;
    logic                      pclk;
    logic                      presetn;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [11:0]               paddr;
    logic [31:0]               pwdata;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [4:0]                evt;
    logic                      sleep_instr;
    logic [4:0]                timer_irq_req;
    logic [2:0]                ext_irq_req;
    logic                      sleep_enter;
    ext_irq_pkg::sleep_mode_e  sleep_mode;
    ext_irq_pkg::ext_mem_cfg_s ext_mem_cfg;
    ext_irq_pkg::timer_evt_s   tack;
    logic [2:0]                eack;
    logic [2:0]                pins;
    logic [31:0]               rdata;
    logic                      rerr;
    int                        errors;
    int                        checks;
    localparam logic [11:0] adr_mcu = 12'h0d4;
    localparam logic [11:0] adr_ext = 12'h0d8;
    localparam logic [11:0] adr_tfl = 12'h0e0;
    localparam logic [11:0] adr_tmk = 12'h0e4;
    localparam logic [11:0] adr_gfl = 12'h0e8;
    localparam logic [11:0] adr_gmk = 12'h0ec;
    localparam logic [11:0] adr_st  = 12'h0fc;
    logic [11:0] all_adr [7] = '{adr_mcu, adr_ext, adr_tfl, adr_tmk,
                                 adr_gfl, adr_gmk, adr_st};

    ext_irq_and_timer_flag_ctrl dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_evt(evt),
        .timer_vec_ack(tack), .ext_vec_ack(eack),
        .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]),
        .ext_irq_pin_c(pins[2]), .sleep_instr(sleep_instr),
        .timer_irq_req(timer_irq_req), .ext_irq_req(ext_irq_req),
        .sleep_enter(sleep_enter), .sleep_mode(sleep_mode),
        .ext_mem_cfg(ext_mem_cfg)
    );

    ext_irq_partner partner (
        .pclk(pclk), .timer_irq_req(timer_irq_req),
        .ext_irq_req(ext_irq_req), .timer_vec_ack(tack),
        .ext_vec_ack(eack), .pins(pins)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            summarize();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, rdata, rerr);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, rdata, rerr);
        check(rdata, exp);
    endtask

    task automatic pulse(input logic [4:0] ev, input logic sl);
        @(posedge pclk);
        evt <= ev;
        sleep_instr <= sl;
        @(posedge pclk);
        evt <= 5'h0;
        sleep_instr <= 1'b0;
    endtask

    initial begin
        logic [1:0] mm;
        logic [3:0] lo_exp;
        logic [3:0] hi_exp;
        lo_exp = 4'h7;
        hi_exp = 4'ha;
        errors = 0;
        checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        evt = 5'h0;
        sleep_instr = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (all_adr[i]) rd(all_adr[i], 32'h0);
        foreach (all_adr[i]) begin
            if (i < 2) begin
                apb(i == 0 ? 12'h000 : 12'h0d5, 1'b0, 32'h0, rdata, rerr);
                check(32'(rerr), 32'h1);
                check(rdata, 32'h0);
            end
        end
        for (int m = 0; m < 4; m++) begin
            mm = m[1:0];
            wr(adr_mcu, {24'h0, mm, 1'b0, mm[1], 4'h0});
            wr(adr_ext, {24'h0, mm[0], 7'h5a});
            @(negedge pclk);
            check(32'(sleep_mode), 32'(mm));
            check(32'(ext_mem_cfg), {24'h0, mm, 6'h2d});
            rd(adr_ext, {24'h0, mm[0], 7'h5a});
        end
        wr(adr_mcu, 32'h0);
        wr(adr_ext, 32'h0);
        // timer flags, global enable still off
        wr(adr_tmk, 32'h1f);
        for (int b = 0; b < 5; b++) begin
            pulse(5'h1 << b, 1'b0);
            @(negedge pclk);
            check(32'(timer_irq_req), 32'h0);
            rd(adr_tfl, 32'h1 << b);
            wr(adr_tfl, 32'h0);
            rd(adr_tfl, 32'h1 << b);
            wr(adr_tfl, 32'h1 << b);
            rd(adr_tfl, 32'h0);
        end
        wr(adr_st, 32'h80);
        pulse(5'h12, 1'b0);
        @(negedge pclk);
        check(32'(timer_irq_req), 32'h12);
        partner.take_vector(2);
        @(negedge pclk);
        check(32'(timer_irq_req), 32'h10);
        partner.take_vector(0);
        @(negedge pclk);
        check(32'(timer_irq_req), 32'h0);
        rd(adr_tfl, 32'h0);
        pulse(5'h08, 1'b0);
        fork
            partner.take_vector(0);
            pulse(5'h08, 1'b0);
        join
        @(negedge pclk);
        check(32'(timer_irq_req), 32'h8);
        wr(adr_tfl, 32'h08);
        wr(adr_tmk, 32'h0);
        // pins a and b through every sense mode
        wr(adr_gmk, 32'he0);
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(adr_mcu, 32'(m) << (2 * p));
                wr(adr_gfl, 32'he0);
                partner.drive_pin(p, 1'b0, 5);
                @(negedge pclk);
                check(32'(ext_irq_req[p]), 32'(lo_exp[m]));
                partner.take_vector(1);
                partner.drive_pin(p, 1'b1, 5);
                @(negedge pclk);
                check(32'(ext_irq_req[p]), 32'(hi_exp[m]));
                partner.take_vector(0);
            end
        end
        wr(adr_st, 32'h0);
        wr(adr_mcu, 32'h02);
        wr(adr_gfl, 32'he0);
        partner.drive_pin(0, 1'b0, 5);
        @(negedge pclk);
        check(32'(ext_irq_req), 32'h0);
        rd(adr_gfl, 32'h40);
        partner.drive_pin(0, 1'b1, 5);
        // pin c, falling then rising edge
        wr(adr_gfl, 32'he0);
        wr(adr_st, 32'h80);
        partner.drive_pin(2, 1'b0, 5);
        @(negedge pclk);
        check(32'(ext_irq_req), 32'h4);
        partner.take_vector(0);
        @(negedge pclk);
        check(32'(ext_irq_req), 32'h0);
        wr(adr_ext, 32'h01);
        wr(adr_gfl, 32'h20);
        partner.drive_pin(2, 1'b1, 5);
        @(negedge pclk);
        check(32'(ext_irq_req), 32'h4);
        partner.take_vector(0);
        // sleep only with the enable bit set just before
        wr(adr_mcu, 32'h0);
        pulse(5'h0, 1'b1);
        @(negedge pclk);
        check(32'(sleep_enter), 32'h0);
        wr(adr_mcu, 32'h20);
        pulse(5'h0, 1'b1);
        @(negedge pclk);
        check(32'(sleep_enter), 32'h1);
        @(negedge pclk);
        check(32'(sleep_enter), 32'h0);
        // second reset in mid-run: registers return to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(adr_mcu, 32'h0);
        rd(adr_st, 32'h0);
        summarize();
    end
endmodule
